// *** design/rsmc_pkg.sv ***
// Package with the constants and types of the reset strap mode capture block.
package rsmc_pkg;

	// Register word offsets on the Avalon-MM slave.
	localparam logic [1:0] RSMC_OFS_STRAP    = 2'h0;
	localparam logic [1:0] RSMC_OFS_EVENT    = 2'h1;
	localparam logic [1:0] RSMC_OFS_IRQ_CFG  = 2'h2;
	localparam logic [1:0] RSMC_OFS_BOOT     = 2'h3;

	// Field positions.
	localparam int RSMC_BIT_BOOT_SRC   = 0;
	localparam int RSMC_BIT_IRQ_STRAP  = 1;
	localparam int RSMC_BIT_TM_ONE     = 2;
	localparam int RSMC_BIT_TM_TWO     = 3;
	localparam int RSMC_BIT_TM_VIOL    = 0;
	localparam int RSMC_LSB_IRQ_EN     = 0;
	localparam int RSMC_LSB_IRQ_EDGE   = 4;
	localparam int RSMC_BIT_BOOT_WAIT  = 0;
	localparam int RSMC_BIT_BOOT_REL   = 1;

	// Number of external interrupt inputs.
	localparam int RSMC_NUM_IRQ = 4;

	// Reset and strap release values.
	localparam logic [3:0]  RSMC_IRQ_OFF      = 4'h0;
	localparam logic [3:0]  RSMC_IRQ_ALL      = 4'hF;
	localparam logic [31:0] RSMC_DATA_ZERO    = 32'h0000_0000;

	// The four shared strap pins, one bit each.
	typedef struct packed {
		logic timer0_expired_pin;
		logic link2_direction_pin;
		logic bus_master_pin;
		logic boot_memory_select_pin;
	} rsmc_pins_type;

	localparam rsmc_pins_type RSMC_PINS_ZERO = 4'h0;

	// Captured strap values.
	typedef struct packed {
		logic test_mode_strap_two;
		logic test_mode_strap_one;
		logic interrupt_enable_strap;
		logic boot_source_strap;
	} rsmc_straps_type;

	localparam rsmc_straps_type RSMC_STRAPS_DEFAULT = 4'h0;

	// Interrupt input configuration.
	typedef struct packed {
		logic [3:0] edge_mode;
		logic [3:0] enable;
	} rsmc_irq_cfg_type;

	localparam rsmc_irq_cfg_type RSMC_IRQ_CFG_RESET = 8'h00;

	// Maps strap pins to strap values.
	function automatic rsmc_straps_type rsmc_pins_to_straps(input rsmc_pins_type p);
		rsmc_straps_type s;
		s.boot_source_strap      = p.boot_memory_select_pin;
		s.interrupt_enable_strap = p.bus_master_pin;
		s.test_mode_strap_one    = p.link2_direction_pin;
		s.test_mode_strap_two    = p.timer0_expired_pin;
		return s;
	endfunction

endpackage

// *** design/rsmc_pin_mux.sv ***
// Shared pin driver: strap input during reset, functional drive afterwards.
`timescale 1ns/1ps
module rsmc_pin_mux (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   clk_en,
	// Control
	input  wire logic                   strap_phase,
	// Functional side
	input  wire rsmc_pkg::rsmc_pins_type func_out,
	input  wire rsmc_pkg::rsmc_pins_type func_oe,
	// Pad side
	output logic                        pad_pulldown_en,
	output rsmc_pkg::rsmc_pins_type     pad_out,
	output rsmc_pkg::rsmc_pins_type     pad_oe
);
	import rsmc_pkg::*;

	// Pins float with the weak pull-down on while straps are sampled.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pad_pulldown_en <= 1'b1;
			pad_out         <= RSMC_PINS_ZERO;
			pad_oe          <= RSMC_PINS_ZERO;
		end else if (clk_en) begin
			pad_pulldown_en <= strap_phase;
			pad_out         <= strap_phase ? RSMC_PINS_ZERO : func_out;
			pad_oe          <= strap_phase ? RSMC_PINS_ZERO : func_oe;
		end
	end
endmodule

// *** design/rsmc_top.sv ***
// Reset strap mode capture with Avalon-MM register access.
`timescale 1ns/1ps
// Overview of operation
// - Sample all strap pins while reset asserted.
// - Undriven strap pin reads default zero.
// - Boot strap zero starts EPROM boot.
// - Boot strap one idles awaiting external load.
// - Interrupt strap zero: inputs disabled, level.
// - Interrupt strap one: inputs enabled, edge.
module rsmc_top (
	// Clock, clock enable and power-on reset
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     clk_en,
	// Device reset phase, high while the device is held in reset
	input  wire logic                     strap_reset_req,
	// Shared strap pins
	input  wire rsmc_pkg::rsmc_pins_type  pin_in,
	output rsmc_pkg::rsmc_pins_type       pin_out,
	output rsmc_pkg::rsmc_pins_type       pin_oe,
	output logic                          pin_pulldown_en,
	// Functional drive of the shared pins
	input  wire rsmc_pkg::rsmc_pins_type  func_out,
	input  wire rsmc_pkg::rsmc_pins_type  func_oe,
	// Boot control
	input  wire logic                     ext_boot_load,
	output logic                          eprom_boot_start,
	output logic                          boot_wait,
	// Interrupt input configuration
	output logic [3:0]                    irq_enable,
	output logic [3:0]                    irq_edge_mode,
	// Captured straps
	output rsmc_pkg::rsmc_straps_type     straps,
	// Avalon-MM slave
	input  wire logic [1:0]               avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [31:0]              avs_writedata,
	input  wire logic [3:0]               avs_byteenable,
	output logic [31:0]                   avs_readdata,
	output logic                          avs_waitrequest
);
	import rsmc_pkg::*;

	logic             phase_q;
	logic             release_pulse;
	rsmc_straps_type  straps_q;
	rsmc_irq_cfg_type irq_cfg_q;
	logic             boot_wait_q;
	logic             boot_start_q;
	logic             tm_viol_q;
	logic             ack_q;
	logic [31:0]      rdata_q;
	logic             req;
	logic             wr_take;
	logic             wr_lo;
	logic [31:0]      rd_mux;
	rsmc_straps_type  sampled;
	logic             wr_event;
	logic             wr_irq_cfg;
	logic             wr_boot;

	assign sampled       = rsmc_pins_to_straps(pin_in);
	// Release is seen in the first cycle after the reset phase drops, with the straps final.
	assign release_pulse = phase_q && !strap_reset_req;

	// Remembers the reset phase to find the cycle in which it ends.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= 1'b1;
		end else if (clk_en) begin
			phase_q <= strap_reset_req;
		end
	end

	// Straps follow the pins through reset, and the last sample is kept. Sampling every
	// cycle lets pins that were still driven when the phase began settle before the end.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			straps_q <= RSMC_STRAPS_DEFAULT;
		end else if (clk_en && strap_reset_req) begin
			straps_q <= sampled;
		end
	end

	// Pads are handed back to the core one cycle after the reset phase ends.
	rsmc_pin_mux u_pin_mux (
		.clk             (clk),
		.rst_b           (rst_b),
		.clk_en          (clk_en),
		.strap_phase     (strap_reset_req),
		.func_out        (func_out),
		.func_oe         (func_oe),
		.pad_pulldown_en (pin_pulldown_en),
		.pad_out         (pin_out),
		.pad_oe          (pin_oe)
	);

	// Boot start pulse or idle wait, chosen by the boot strap at release.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_start_q <= 1'b0;
		end else if (clk_en) begin
			boot_start_q <= release_pulse && !straps_q.boot_source_strap;
		end
	end

	// The software release serves a loader that cannot raise ext_boot_load itself.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_wait_q <= 1'b0;
		end else if (clk_en) begin
			if (strap_reset_req) begin
				boot_wait_q <= 1'b0;
			end else if (release_pulse) begin
				boot_wait_q <= straps_q.boot_source_strap;
			end else if (ext_boot_load) begin
				boot_wait_q <= 1'b0;
			end else if (wr_boot && avs_writedata[RSMC_BIT_BOOT_REL]) begin
				boot_wait_q <= 1'b0;
			end
		end
	end

	// Interrupt configuration is loaded from the strap and may be changed later.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_cfg_q <= RSMC_IRQ_CFG_RESET;
		end else if (clk_en) begin
			if (strap_reset_req) begin
				irq_cfg_q <= RSMC_IRQ_CFG_RESET;
			end else if (release_pulse) begin
				if (straps_q.interrupt_enable_strap) begin
					irq_cfg_q.enable    <= RSMC_IRQ_ALL;
					irq_cfg_q.edge_mode <= RSMC_IRQ_ALL;
				end else begin
					irq_cfg_q.enable    <= RSMC_IRQ_OFF;
					irq_cfg_q.edge_mode <= RSMC_IRQ_OFF;
				end
			end else if (wr_irq_cfg) begin
				irq_cfg_q.enable    <= avs_writedata[RSMC_LSB_IRQ_EN +: RSMC_NUM_IRQ];
				irq_cfg_q.edge_mode <= avs_writedata[RSMC_LSB_IRQ_EDGE +: RSMC_NUM_IRQ];
			end
		end
	end

	// A test strap seen high is flagged; a new detection beats a clear.
	// The flag only reports the misuse; the reserved test modes are never entered.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tm_viol_q <= 1'b0;
		end else if (clk_en) begin
			if (release_pulse && (straps_q.test_mode_strap_one
				|| straps_q.test_mode_strap_two)) begin
				tm_viol_q <= 1'b1;
			end else if (wr_event && avs_writedata[RSMC_BIT_TM_VIOL]) begin
				tm_viol_q <= 1'b0;
			end
		end
	end

	// Every access waits one enabled cycle, so read data comes from a flop.
	assign req             = avs_read || avs_write;
	// An access ends only on an enabled edge; ending it in a frozen cycle would drop the write,
	// since it is taken on that same edge. Read data is loaded one enabled edge earlier, as ack_q rises.
	assign avs_waitrequest = req && !(ack_q && clk_en);
	assign wr_take         = clk_en && avs_write && ack_q;
	assign wr_lo           = avs_byteenable[0];

	// Write strobe of one register word. A write without byte lane zero is dropped whole,
	// so a partial write never leaves a field half updated.
	function automatic logic reg_wr_hit(input logic take, input logic [1:0] addr,
		input logic [1:0] ofs);
		return take && (addr == ofs);
	endfunction

	assign wr_event   = reg_wr_hit(wr_take && wr_lo, avs_address, RSMC_OFS_EVENT);
	assign wr_irq_cfg = reg_wr_hit(wr_take && wr_lo, avs_address, RSMC_OFS_IRQ_CFG);
	assign wr_boot    = reg_wr_hit(wr_take && wr_lo, avs_address, RSMC_OFS_BOOT);

	// The acknowledge falls back after one answer, so a held request is answered again every second enabled cycle.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else if (clk_en) begin
			ack_q <= req && !ack_q;
		end
	end

	always_comb begin
		rd_mux = RSMC_DATA_ZERO;
		unique case (avs_address)
			RSMC_OFS_STRAP: begin
				rd_mux[RSMC_BIT_BOOT_SRC]  = straps_q.boot_source_strap;
				rd_mux[RSMC_BIT_IRQ_STRAP] = straps_q.interrupt_enable_strap;
				rd_mux[RSMC_BIT_TM_ONE]    = straps_q.test_mode_strap_one;
				rd_mux[RSMC_BIT_TM_TWO]    = straps_q.test_mode_strap_two;
			end
			RSMC_OFS_EVENT:   rd_mux[RSMC_BIT_TM_VIOL] = tm_viol_q;
			RSMC_OFS_IRQ_CFG: begin
				rd_mux[RSMC_LSB_IRQ_EN +: RSMC_NUM_IRQ]   = irq_cfg_q.enable;
				rd_mux[RSMC_LSB_IRQ_EDGE +: RSMC_NUM_IRQ] = irq_cfg_q.edge_mode;
			end
			RSMC_OFS_BOOT:    rd_mux[RSMC_BIT_BOOT_WAIT] = boot_wait_q;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= RSMC_DATA_ZERO;
		end else if (clk_en && avs_read && !ack_q) begin
			rdata_q <= rd_mux;
		end
	end

	assign avs_readdata     = rdata_q;
	assign eprom_boot_start = boot_start_q;
	assign boot_wait        = boot_wait_q;
	assign irq_enable       = irq_cfg_q.enable;
	assign irq_edge_mode    = irq_cfg_q.edge_mode;
	assign straps           = straps_q;
endmodule

// *** dv/rsmc_assertions.sv ***
// Checker of strap capture, release outcome and pin hand-back.
`timescale 1ns/1ps
module rsmc_assertions (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst_b,
	input wire logic                      clk_en,
	// Watched ports
	input wire logic                      strap_reset_req,
	input wire rsmc_pkg::rsmc_pins_type   pin_in,
	input wire rsmc_pkg::rsmc_pins_type   pin_oe,
	input wire logic                      pin_pulldown_en,
	input wire logic                      eprom_boot_start,
	input wire logic                      boot_wait,
	input wire logic [3:0]                irq_enable,
	input wire logic [3:0]                irq_edge_mode,
	input wire rsmc_pkg::rsmc_straps_type straps
);
	import rsmc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_rel;
		clk_en && $past(strap_reset_req) && !strap_reset_req;
	endsequence
	property p_cap; strap_reset_req && clk_en |=> straps == $past(pin_in); endproperty
	property p_hold; !strap_reset_req |=> $stable(straps); endproperty
	property p_pads;
		strap_reset_req && clk_en |=> pin_oe == RSMC_PINS_ZERO && pin_pulldown_en;
	endproperty
	property p_func; (!strap_reset_req && clk_en) [*3] |-> !pin_pulldown_en; endproperty
	property p_eprom;
		s_rel ##0 !straps.boot_source_strap |=> eprom_boot_start ##1 !eprom_boot_start;
	endproperty
	property p_wait;
		s_rel ##0 straps.boot_source_strap |=> boot_wait && !eprom_boot_start;
	endproperty
	property p_irq_off;
		s_rel ##0 !straps.interrupt_enable_strap |=>
			irq_enable == RSMC_IRQ_OFF && irq_edge_mode == RSMC_IRQ_OFF;
	endproperty
	property p_irq_on;
		s_rel ##0 straps.interrupt_enable_strap |=>
			irq_enable == RSMC_IRQ_ALL && irq_edge_mode == RSMC_IRQ_ALL;
	endproperty
	a_cap: assert property (p_cap) else $error("strap not captured");
	a_hold: assert property (p_hold) else $error("strap moved after reset");
	a_pads: assert property (p_pads) else $error("pad driven in strap phase");
	a_func: assert property (p_func) else $error("pull-down left on");
	a_eprom: assert property (p_eprom) else $error("no boot pulse");
	a_wait: assert property (p_wait) else $error("no boot wait");
	a_irq_off: assert property (p_irq_off) else $error("irq not off");
	a_irq_on: assert property (p_irq_on) else $error("irq not on");
endmodule
bind rsmc_top rsmc_assertions u_chk (.clk, .rst_b, .clk_en, .strap_reset_req, .pin_in,
	.pin_oe, .pin_pulldown_en, .eprom_boot_start, .boot_wait, .irq_enable,
	.irq_edge_mode, .straps);

// *** dv/rsmc_board.sv ***
// Board strap resistors and resolved pad level of the shared pins.
`timescale 1ns/1ps
module rsmc_board (
	// Clock
	input wire logic                    clk,
	// Board pull-ups, one per set bit
	input wire logic [3:0]              pull_up,
	// Device pad side
	input wire rsmc_pkg::rsmc_pins_type pin_out,
	input wire rsmc_pkg::rsmc_pins_type pin_oe,
	input wire logic                    pin_pulldown_en,
	output rsmc_pkg::rsmc_pins_type     pin_in
);
	logic toggle_q = 1'b0;
	// A floating pin wanders, so a capture of an undriven pin cannot pass by luck.
	always @(posedge clk) begin
		toggle_q <= !toggle_q;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (pull_up[i])
				pin_in[i] = 1'b1;
			else if (pin_pulldown_en)
				pin_in[i] = 1'b0;
			else
				pin_in[i] = toggle_q ^ i[0];
		end
	end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench of the strap capture block.
`timescale 1ns/1ps
module testbench;
	import rsmc_pkg::*;
	logic            clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, strap_reset_req = 1'b1;
	logic            ext_boot_load = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic            pin_pulldown_en, eprom_boot_start, boot_wait, avs_waitrequest;
	logic [1:0]      avs_address = 2'h0;
	logic [3:0]      avs_byteenable = 4'hF, be = 4'hF, pull_up = 4'h0;
	logic [3:0]      irq_enable, irq_edge_mode;
	logic [31:0]     avs_writedata = 32'h0, avs_readdata, q;
	rsmc_pins_type   pin_in, pin_out, pin_oe, func_out = 4'h0, func_oe = 4'h0;
	rsmc_straps_type straps;
	int              seed = 32'hfba3, n_mismatch = 0, checked = 0;
	logic            ce_rand = 1'b0;
	// Test straps are pulled high only in the last two corners.
	logic [3:0]      corner [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
	always #4 clk = !clk;
	// In marked stretches the clock enable drops at random to stretch bus accesses.
	always @(posedge clk) clk_en <= ce_rand ? 1'($random(seed)) : 1'b1;
	rsmc_top uut (.clk, .rst_b, .clk_en, .strap_reset_req, .pin_in, .pin_out, .pin_oe,
		.pin_pulldown_en, .func_out, .func_oe, .ext_boot_load, .eprom_boot_start,
		.boot_wait, .irq_enable, .irq_edge_mode, .straps, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
	rsmc_board board (.clk, .pull_up, .pin_out, .pin_oe, .pin_pulldown_en, .pin_in);
	function automatic logic [7:0] exp_irq(input logic [3:0] s);
		return {8{s[1]}};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clk);
			q = avs_readdata;
			k++;
			if (k > 60) begin
				n_mismatch++;
				results();
			end
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic phase(input logic [3:0] s);
		@(posedge clk);
		pull_up <= s;
		strap_reset_req <= 1'b1;
		func_out <= $random(seed);
		func_oe <= $random(seed);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(pin_oe, 0);
		chk(pin_pulldown_en, 1);
		@(posedge clk);
		strap_reset_req <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(straps, s);
		chk(eprom_boot_start, !s[0]);
		chk(boot_wait, s[0]);
		chk({irq_edge_mode, irq_enable}, exp_irq(s));
		@(negedge clk);
		chk(eprom_boot_start, 0);
	endtask
	initial begin
		logic [3:0] s;
		logic [7:0] v;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		for (int n = 0; n < 12; n++) begin
			s = (n < 6) ? corner[n] : 4'($random(seed)) & 4'h3;
			be = 4'hF;
			phase(s);
			ce_rand <= n[0];
			bus(0, RSMC_OFS_STRAP, 0);
			chk(q, s);
			bus(1, RSMC_OFS_STRAP, 32'hF);
			bus(0, RSMC_OFS_STRAP, 0);
			chk(q, s);
			bus(0, RSMC_OFS_EVENT, 0);
			chk(q, 32'(s[2] | s[3]));
			bus(1, RSMC_OFS_EVENT, 1);
			bus(0, RSMC_OFS_EVENT, 0);
			chk(q, 0);
			// The boot release is a single pulse, which a frozen cycle would swallow.
			ce_rand <= 1'b0;
			if (s[0] && n[0]) begin
				@(posedge clk);
				ext_boot_load <= 1'b1;
				@(posedge clk);
				ext_boot_load <= 1'b0;
			end else if (s[0])
				bus(1, RSMC_OFS_BOOT, 2);
			@(negedge clk);
			chk(boot_wait, 0);
			v = $random(seed);
			be = $random(seed);
			ce_rand <= n[0];
			bus(1, RSMC_OFS_IRQ_CFG, v);
			bus(0, RSMC_OFS_IRQ_CFG, 0);
			chk(q, be[0] ? v : exp_irq(s));
			ce_rand <= 1'b0;
			chk(pin_oe, func_oe);
			chk(pin_out, func_out);
		end
		results();
	end
endmodule
